// File: src/cpm_pkg.sv
package cpm_pkg;

    localparam int DEV_AW = 8;
    localparam int DEV_DW = 8;
    localparam int CAP_W = 16;
    localparam int OVF_W = 8;
    localparam int RES_W = 24;

    // Device register offsets seen on the device's byte-wide register port.
    localparam logic [7:0] TIMER_CTRL_STATUS_ADDR = 8'h01;
    localparam logic [7:0] COUNTER_HI_ADDR = 8'h02;
    localparam logic [7:0] CAPTURE_HI_ADDR = 8'h04;
    localparam logic [7:0] CAPTURE_LO_ADDR = 8'h05;

    // Bit positions inside timer_ctrl_status.
    localparam int CAPTURE_FLAG_BIT = 7;
    localparam int COUNTER_OVERFLOW_FLAG_BIT = 5;
    localparam int CAPTURE_EDGE_POLARITY_BIT = 1;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [OVF_W-1:0] OVF_RESET = 8'h00;

    // One register access holds the strobe for at least this long.
    localparam int CLK_PERIOD_NS = 10;
    localparam int ACC_TIME_NS = 40;
    localparam int ACC_CYCLES = (ACC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] ACC_LAST = 4'(ACC_CYCLES - 1);

    typedef struct packed {
        logic we;
        logic [DEV_AW-1:0] addr;
        logic [DEV_DW-1:0] wdata;
    } cpm_req_t;

    typedef enum {
        S_IDLE,
        S_SET_EDGE,
        S_CLR_ST,
        S_CLR_CAPH,
        S_CLR_CAPL,
        S_CLR_CNT,
        S_POLL,
        S_CAP_H,
        S_CAP_L,
        S_EDGE2,
        S_OVF_CLR
    } cpm_state_t;

endpackage : cpm_pkg

// File: src/cpm_dev_port.sv
`timescale 1ns/10ps
module cpm_dev_port import cpm_pkg::*; (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic req_valid_i,
    input wire cpm_req_t req_i,
    output logic busy_o,
    output logic ack_o,
    output logic [DEV_DW-1:0] rdata_o,
    output logic [DEV_AW-1:0] dev_addr_o,
    output logic dev_rd_o,
    output logic dev_wr_o,
    output logic [DEV_DW-1:0] dev_data_o,
    output logic dev_data_oe_o,
    input wire logic [DEV_DW-1:0] dev_data_i
);

    logic [DEV_DW-1:0] data_s1;
    logic [DEV_DW-1:0] data_s2;
    logic [3:0] cnt;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_s1 <= 8'h00;
            data_s2 <= 8'h00;
        end else begin
            data_s1 <= dev_data_i;
            data_s2 <= data_s1;
        end
    end

    // The strobe is held for ACC_CYCLES; read data is taken from the second
    // synchroniser stage in the last cycle, so the device has settled by then.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
            ack_o <= 1'b0;
            cnt <= 4'h0;
            rdata_o <= 8'h00;
            dev_addr_o <= 8'h00;
            dev_rd_o <= 1'b0;
            dev_wr_o <= 1'b0;
            dev_data_o <= 8'h00;
            dev_data_oe_o <= 1'b0;
        end else begin
            ack_o <= 1'b0;
            if (!busy_o && req_valid_i) begin
                busy_o <= 1'b1;
                cnt <= ACC_LAST;
                dev_addr_o <= req_i.addr;
                dev_rd_o <= !req_i.we;
                dev_wr_o <= req_i.we;
                dev_data_o <= req_i.wdata;
                dev_data_oe_o <= req_i.we;
            end else if (busy_o) begin
                if (cnt == 4'h0) begin
                    busy_o <= 1'b0;
                    ack_o <= 1'b1;
                    rdata_o <= data_s2;
                    dev_rd_o <= 1'b0;
                    dev_wr_o <= 1'b0;
                    dev_data_oe_o <= 1'b0;
                end else begin
                    cnt <= cnt - 4'h1;
                end
            end
        end
    end

    acc_len_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(busy_o) |-> busy_o [*4] ##1 (ack_o && !busy_o))
        else $error("access length wrong");

endmodule : cpm_dev_port

// File: src/cpm_host.sv
`timescale 1ns/10ps
module cpm_host import cpm_pkg::*; (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic long_mode_i,
    input wire logic capture_edge_polarity_i,
    input wire logic toggle_edge_i,
    output logic busy_o,
    output logic done_o,
    output logic [RES_W-1:0] period_o,
    output logic [DEV_AW-1:0] dev_addr_o,
    output logic dev_rd_o,
    output logic dev_wr_o,
    output logic [DEV_DW-1:0] dev_data_o,
    output logic dev_data_oe_o,
    input wire logic [DEV_DW-1:0] dev_data_i
);

    cpm_state_t state;
    logic issued;
    logic acc_busy;
    logic acc_ack;
    logic [DEV_DW-1:0] acc_rdata;
    logic acc_req_valid;
    cpm_req_t acc_req;
    logic phase;
    logic long_q;
    logic tog_q;
    logic edge_q;
    logic pend_ovf;
    logic cleared;
    logic [DEV_DW-1:0] status;
    logic [7:0] cap_hi;
    logic [CAP_W-1:0] first_capture_value;
    logic [OVF_W-1:0] ovf_cnt;
    logic [DEV_AW-1:0] last_rd_addr;
    logic [CAP_W-1:0] second_capture_value;

    function automatic cpm_req_t req_of(input cpm_state_t s, input logic edge_v);
        cpm_req_t r;
        r.we = 1'b0;
        r.addr = TIMER_CTRL_STATUS_ADDR;
        r.wdata = CTRL_RESET;
        case (s)
            S_SET_EDGE, S_EDGE2: begin
                r.we = 1'b1;
                r.wdata[CAPTURE_EDGE_POLARITY_BIT] = edge_v;
            end
            S_CLR_CAPH, S_CAP_H: r.addr = CAPTURE_HI_ADDR;
            S_CLR_CAPL, S_CAP_L: r.addr = CAPTURE_LO_ADDR;
            S_CLR_CNT, S_OVF_CLR: r.addr = COUNTER_HI_ADDR;
            default: r.addr = TIMER_CTRL_STATUS_ADDR;
        endcase
        return r;
    endfunction : req_of

    // Final 24-bit period from overflow count and both captures.
    function automatic logic [RES_W-1:0] period_of(input logic [OVF_W-1:0] n,
                                                   input logic [CAP_W-1:0] t1,
                                                   input logic [CAP_W-1:0] t0);
        logic [CAP_W-1:0] diff;
        logic borrow;
        diff = t1 - t0;
        borrow = t1 < t0;
        return {n - OVF_W'(borrow), diff};
    endfunction : period_of

    assign acc_req_valid = (state != S_IDLE) && !issued && !acc_busy;
    assign acc_req = req_of(state, state == S_EDGE2 ? !edge_q : edge_q);

    cpm_dev_port u_port (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .req_valid_i(acc_req_valid),
        .req_i(acc_req),
        .busy_o(acc_busy),
        .ack_o(acc_ack),
        .rdata_o(acc_rdata),
        .dev_addr_o(dev_addr_o),
        .dev_rd_o(dev_rd_o),
        .dev_wr_o(dev_wr_o),
        .dev_data_o(dev_data_o),
        .dev_data_oe_o(dev_data_oe_o),
        .dev_data_i(dev_data_i)
    );

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            issued <= 1'b0;
        end else if (acc_ack) begin
            issued <= 1'b0;
        end else if (acc_req_valid) begin
            issued <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            last_rd_addr <= 8'h00;
        end else if (acc_req_valid && !acc_req.we) begin
            last_rd_addr <= acc_req.addr;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= S_IDLE;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            period_o <= 24'h000000;
            phase <= 1'b0;
            long_q <= 1'b0;
            tog_q <= 1'b0;
            edge_q <= 1'b0;
            pend_ovf <= 1'b0;
            cleared <= 1'b0;
            status <= 8'h00;
            cap_hi <= 8'h00;
            first_capture_value <= 16'h0000;
            second_capture_value <= 16'h0000;
            ovf_cnt <= OVF_RESET;
        end else begin
            done_o <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (start_i) begin
                        busy_o <= 1'b1;
                        phase <= 1'b0;
                        cleared <= 1'b0;
                        pend_ovf <= 1'b0;
                        ovf_cnt <= OVF_RESET;
                        long_q <= long_mode_i;
                        tog_q <= toggle_edge_i;
                        edge_q <= capture_edge_polarity_i;
                        state <= S_SET_EDGE;
                    end
                end
                S_SET_EDGE: if (acc_ack) state <= S_CLR_ST;
                S_CLR_ST: if (acc_ack) state <= S_CLR_CAPH;
                S_CLR_CAPH: if (acc_ack) state <= S_CLR_CAPL;
                S_CLR_CAPL: if (acc_ack) state <= S_CLR_CNT;
                S_CLR_CNT: begin
                    if (acc_ack) begin
                        cleared <= 1'b1;
                        state <= S_POLL;
                    end
                end
                S_POLL: begin
                    if (acc_ack) begin
                        status <= acc_rdata;
                        if (acc_rdata[CAPTURE_FLAG_BIT]) begin
                            state <= S_CAP_H;
                        end else if (acc_rdata[COUNTER_OVERFLOW_FLAG_BIT] && long_q) begin
                            if (phase) begin
                                ovf_cnt <= ovf_cnt + 8'h01;
                            end
                            state <= S_OVF_CLR;
                        end else begin
                            state <= S_POLL;
                        end
                    end
                end
                S_CAP_H: begin
                    if (acc_ack) begin
                        cap_hi <= acc_rdata;
                        state <= S_CAP_L;
                    end
                end
                S_CAP_L: begin
                    if (acc_ack) begin
                        if (!phase) begin
                            first_capture_value <= {cap_hi, acc_rdata};
                            phase <= 1'b1;
                            pend_ovf <= long_q && status[COUNTER_OVERFLOW_FLAG_BIT];
                            if (long_q && status[COUNTER_OVERFLOW_FLAG_BIT] && cap_hi[7]) begin
                                ovf_cnt <= ovf_cnt + 8'h01;
                            end
                            if (tog_q) begin
                                state <= S_EDGE2;
                            end else if (long_q && status[COUNTER_OVERFLOW_FLAG_BIT]) begin
                                state <= S_OVF_CLR;
                            end else begin
                                state <= S_POLL;
                            end
                        end else begin
                            second_capture_value <= {cap_hi, acc_rdata};
                            if (!long_q) begin
                                period_o <= period_of(8'h00, {cap_hi, acc_rdata},
                                                      first_capture_value);
                            end else if (status[COUNTER_OVERFLOW_FLAG_BIT] && !cap_hi[7]) begin
                                period_o <= period_of(ovf_cnt + 8'h01, {cap_hi, acc_rdata},
                                                      first_capture_value);
                            end else begin
                                period_o <= period_of(ovf_cnt, {cap_hi, acc_rdata},
                                                      first_capture_value);
                            end
                            done_o <= 1'b1;
                            busy_o <= 1'b0;
                            state <= S_IDLE;
                        end
                    end
                end
                S_EDGE2: begin
                    if (acc_ack) begin
                        edge_q <= !edge_q;
                        state <= pend_ovf ? S_OVF_CLR : S_POLL;
                    end
                end
                S_OVF_CLR: begin
                    if (acc_ack) begin
                        pend_ovf <= 1'b0;
                        state <= S_POLL;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    cap_clear_seq_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state == S_CAP_H && acc_req_valid) |-> last_rd_addr == TIMER_CTRL_STATUS_ADDR)
        else $error("capture read not preceded by status read");

    edge_toggle_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ($rose(phase) && tog_q) |-> ##[1:12] (dev_wr_o
            && dev_data_o[CAPTURE_EDGE_POLARITY_BIT] != edge_q))
        else $error("edge polarity not toggled after first capture");

    short_diff_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (done_o && !long_q) |-> period_o ==
            {8'h00, second_capture_value - first_capture_value})
        else $error("short period wrong");

    borrow_dec_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state == S_CAP_L && acc_ack && phase && long_q
            && !status[COUNTER_OVERFLOW_FLAG_BIT]
            && {cap_hi, acc_rdata} < first_capture_value)
        |=> period_o[23:16] == $past(ovf_cnt) - 8'h01)
        else $error("borrow not subtracted");

    flags_cleared_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(phase) |-> $past(cleared))
        else $error("first capture before flags cleared");

    ovf_count_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state == S_POLL && acc_ack && phase && long_q
            && !acc_rdata[CAPTURE_FLAG_BIT] && acc_rdata[COUNTER_OVERFLOW_FLAG_BIT])
        |=> ovf_cnt == $past(ovf_cnt) + 8'h01)
        else $error("overflow not counted");

    ovf_service_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state == S_POLL && acc_ack && long_q
            && !acc_rdata[CAPTURE_FLAG_BIT] && acc_rdata[COUNTER_OVERFLOW_FLAG_BIT])
        |-> ##[1:12] (state == S_OVF_CLR && acc_ack))
        else $error("overflow flag not cleared in time");

    cap_first_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state == S_POLL && acc_ack && acc_rdata[CAPTURE_FLAG_BIT]) |=> state == S_CAP_H)
        else $error("capture not serviced first");

    first_wrap_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state == S_CAP_L && acc_ack && !phase && long_q && status[COUNTER_OVERFLOW_FLAG_BIT])
        |=> ovf_cnt == ($past(cap_hi[7]) ? 8'h01 : 8'h00))
        else $error("first capture rollover resolved wrong");

    second_wrap_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state == S_CAP_L && acc_ack && phase && long_q && status[COUNTER_OVERFLOW_FLAG_BIT]
            && !cap_hi[7] && {cap_hi, acc_rdata} >= first_capture_value)
        |=> period_o[23:16] == $past(ovf_cnt) + 8'h01)
        else $error("second capture rollover resolved wrong");

    done_pulse_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        done_o |=> (!done_o && !busy_o))
        else $error("done not a single pulse");

    short_done_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        done_o && !long_q);
    long_ovf_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        done_o && long_q && period_o[23:16] != 8'h00);
    toggle_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        state == S_EDGE2 && acc_ack);

endmodule : cpm_host

// File: tb/cpm_dev_model.sv
`timescale 1ns/10ps
module cpm_dev_model import cpm_pkg::*; (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [DEV_AW-1:0] addr_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [DEV_DW-1:0] wdata_i,
    input wire logic cap_in_i,
    output logic [DEV_DW-1:0] data_o
);
    logic [15:0] counter, capture;
    logic cap_flag, ovf_flag, edge_pol, cap_q, rd_q, wr_q, arm_cap, arm_ovf, cap_hit;
    logic [7:0] rdata, status;
    assign status = (8'(cap_flag) << CAPTURE_FLAG_BIT)
        | (8'(ovf_flag) << COUNTER_OVERFLOW_FLAG_BIT)
        | (8'(edge_pol) << CAPTURE_EDGE_POLARITY_BIT);
    // A level is seen once per cycle, so any pulse two cycles wide is caught.
    assign cap_hit = (cap_in_i != cap_q) && (cap_in_i == edge_pol);
    // Read data stands only from the second cycle of the strobe until it drops; otherwise the bus shows its inverse.
    assign data_o = (rd_i && rd_q) ? rdata : ~rdata;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            counter <= 16'h0000;
            capture <= 16'h0000;
            {cap_flag, ovf_flag, edge_pol, cap_q, rd_q, wr_q, arm_cap, arm_ovf} <= 8'h00;
            rdata <= 8'h00;
        end else begin
            counter <= counter + 16'h0001;
            cap_q <= cap_in_i;
            rd_q <= rd_i;
            wr_q <= wr_i;
            if (wr_i && !wr_q && addr_i == TIMER_CTRL_STATUS_ADDR) begin
                edge_pol <= wdata_i[CAPTURE_EDGE_POLARITY_BIT];
            end
            if (rd_i && !rd_q) begin
                case (addr_i)
                    TIMER_CTRL_STATUS_ADDR: begin
                        rdata <= status;
                        arm_cap <= cap_flag;
                        arm_ovf <= ovf_flag;
                    end
                    CAPTURE_HI_ADDR: begin
                        rdata <= capture[15:8];
                        cap_flag <= cap_flag & ~arm_cap;
                        arm_cap <= 1'b0;
                    end
                    CAPTURE_LO_ADDR: rdata <= capture[7:0];
                    COUNTER_HI_ADDR: begin
                        rdata <= counter[15:8];
                        ovf_flag <= ovf_flag & ~arm_ovf;
                        arm_ovf <= 1'b0;
                    end
                    default: rdata <= 8'hFF;
                endcase
            end
            if (counter == 16'hFFFF) begin
                ovf_flag <= 1'b1;
            end
            if (cap_hit) begin
                capture <= counter;
                cap_flag <= 1'b1;
            end
        end
    end
endmodule : cpm_dev_model

// File: tb/cpm_host_bench.sv
`timescale 1ns/10ps
module cpm_host_bench import cpm_pkg::*;;
    logic ref_clk, rst, start, long_mode, pol, toggle, cap_in, busy, done, dev_rd, dev_wr, dev_oe;
    logic [RES_W-1:0] period;
    logic [DEV_AW-1:0] dev_addr;
    logic [DEV_DW-1:0] dev_wdata, dev_rdata;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;

    cpm_host dut_u (.ref_clk_i(ref_clk), .rst_i(rst), .start_i(start), .long_mode_i(long_mode),
        .capture_edge_polarity_i(pol), .toggle_edge_i(toggle), .busy_o(busy), .done_o(done),
        .period_o(period), .dev_addr_o(dev_addr), .dev_rd_o(dev_rd), .dev_wr_o(dev_wr),
        .dev_data_o(dev_wdata), .dev_data_oe_o(dev_oe), .dev_data_i(dev_rdata));
    cpm_dev_model dev_u (.ref_clk_i(ref_clk), .rst_i(rst), .addr_i(dev_addr), .rd_i(dev_rd),
        .wr_i(dev_wr), .wdata_i(dev_wdata), .cap_in_i(cap_in), .data_o(dev_rdata));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic test_done;
        if (err_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 90000) begin
            err_count++;
            $display("ERROR %0t run did not finish", $time);
            test_done();
        end
    end

    task automatic cmp_period(input logic [RES_W-1:0] got, input logic [RES_W-1:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t period %h expected %h", $time, got, exp);
        end
    endtask : cmp_period

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t %s is %b expected %b", $time, what, got, exp);
        end
    endtask : cmp_bit

    // Input goes high at 100 cycles after start, low h later, high again p after the first
    // rise and low h after that. A second start is offered while busy and must be ignored.
    task automatic measure(input logic lm, input logic pl, input logic tg, input int h,
        input int p, output logic [RES_W-1:0] res);
        int i;
        @(negedge ref_clk);
        long_mode = lm;
        pol = pl;
        toggle = tg;
        start = 1'b1;
        @(negedge ref_clk);
        start = 1'b0;
        fork
            begin
                repeat (100) @(negedge ref_clk);
                cap_in = 1'b1;
                repeat (h) @(negedge ref_clk);
                cap_in = 1'b0;
                start = 1'b1;
                @(negedge ref_clk);
                start = 1'b0;
                repeat (p - h - 1) @(negedge ref_clk);
                cap_in = 1'b1;
                repeat (h) @(negedge ref_clk);
                cap_in = 1'b0;
            end
            begin
                for (i = 0; i < p + h + 400 && done !== 1'b1; i++) @(negedge ref_clk);
                cmp_bit(done, 1'b1, "done");
                res = period;
            end
        join
        repeat (5) @(negedge ref_clk);
        cmp_bit(busy, 1'b0, "busy after refused start");
    endtask : measure

    task automatic test_reset;
        cmp_bit(busy, 1'b0, "busy");
        cmp_bit(done, 1'b0, "done");
        cmp_bit(dev_rd, 1'b0, "read strobe");
        cmp_bit(dev_wr, 1'b0, "write strobe");
        cmp_bit(dev_oe, 1'b0, "data enable");
        cmp_period(period, 24'h000000);
    endtask : test_reset

    task automatic test_rise_rise;
        logic [RES_W-1:0] r;
        measure(1'b0, 1'b1, 1'b0, 200, 600, r);
        cmp_period(r, 24'(600));
    endtask : test_rise_rise

    task automatic test_rise_fall;
        logic [RES_W-1:0] r;
        measure(1'b0, 1'b1, 1'b1, 150, 500, r);
        cmp_period(r, 24'(150));
    endtask : test_rise_fall

    task automatic test_fall_fall;
        logic [RES_W-1:0] r;
        measure(1'b0, 1'b0, 1'b0, 100, 700, r);
        cmp_period(r, 24'(700));
    endtask : test_fall_fall

    task automatic test_fall_rise;
        logic [RES_W-1:0] r;
        measure(1'b0, 1'b0, 1'b1, 300, 800, r);
        cmp_period(r, 24'(800 - 300));
    endtask : test_fall_rise

    task automatic test_long;
        logic [RES_W-1:0] r;
        measure(1'b1, 1'b1, 1'b0, 20, 70000, r);
        cmp_period(r, 24'((70000 / 65536) * 65536 + (70000 % 65536)));
    endtask : test_long

    initial begin
        rst = 1'b1;
        start = 1'b0;
        long_mode = 1'b0;
        pol = 1'b0;
        toggle = 1'b0;
        cap_in = 1'b0;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        test_reset();
        test_rise_rise();
        test_rise_fall();
        test_fall_fall();
        test_fall_rise();
        test_long();
        test_done();
    end
endmodule : cpm_host_bench
